// *** rtl/light_timing_pkg.sv ***
// Constants shared by the light integration timing core and its oscillator.
package light_timing_pkg;

  // ********************************************************************
  // Clock and oscillator rates
  // ********************************************************************
  localparam int CLOCK_KHZ = 125000;
  localparam int OSC_FULL_KHZ = 684;
  localparam int OSC_HALF_KHZ = 342;
  // Clock cycles per oscillator cycle at full speed, rounded down.
  localparam int OSC_FULL_DIV = CLOCK_KHZ / OSC_FULL_KHZ;
  localparam int OSC_HALF_DIV = 2 * OSC_FULL_DIV;
  localparam int DIV_W = 9;

  // ********************************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************************
  localparam logic [3:0] IDX_COMMAND = 4'h0;
  localparam logic [3:0] IDX_CONTROL = 4'h1;
  localparam logic [3:0] IDX_DATA_LO = 4'h4;
  localparam logic [3:0] IDX_DATA_HI = 4'h5;
  localparam logic [3:0] IDX_TIMER_LO = 4'h6;
  localparam logic [3:0] IDX_TIMER_HI = 4'h7;
  localparam logic [3:0] IDX_SYNC = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;
  localparam logic [3:0] IDX_FULL_LO = 4'ha;
  localparam logic [3:0] IDX_FULL_HI = 4'hb;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int CMD_ENABLE_BIT = 7;
  localparam int CMD_MODE_BIT = 5;
  localparam int CMD_WIDTH_LSB = 0;
  localparam int CTRL_GAIN_LSB = 2;
  localparam int STAT_OVF_BIT = 0;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ********************************************************************
  // Cycles per conversion selected by the width field
  // ********************************************************************
  localparam logic [16:0] CYCLES_W00 = 17'h10000;
  localparam logic [16:0] CYCLES_W01 = 17'h01000;
  localparam logic [16:0] CYCLES_W10 = 17'h00100;
  localparam logic [16:0] CYCLES_W11 = 17'h00010;

  // Host-timed measurement phase.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ARRAY1 = 2'b01,
    PH_ARRAY2 = 2'b10
  } phase_e;

endpackage

// *** rtl/osc_if.sv ***
// Link between the timing core and its conversion oscillator.
`timescale 1ns/1ns
`default_nettype none
interface osc_if;
  logic enable;
  logic fast;
  logic tick;
  modport core (output enable, output fast, input tick);
  modport osc (input enable, input fast, output tick);
endinterface
`default_nettype wire

// *** rtl/conv_oscillator.sv ***
// Dual speed conversion oscillator derived from the system clock.
`timescale 1ns/1ns
`default_nettype none
module conv_oscillator
  import light_timing_pkg::*;
(
  // System
  input wire logic CLOCK,
  input wire logic RESET,
  // Core side
  osc_if.osc link
);

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic fast_ff;
  logic tick_ff;
  logic nxt_tick;
  logic [DIV_W-1:0] last;

  // Half speed gain.
  // A speed change restarts the divider so the new rate holds at once.
  always_comb begin
    last = link.fast ? DIV_W'(OSC_FULL_DIV - 1) : DIV_W'(OSC_HALF_DIV - 1);
    nxt_tick = 1'b0;
    nxt_div = div_ff + 1'b1;
    if (!link.enable || link.fast != fast_ff) begin
      nxt_div = '0;
    end else if (div_ff >= last) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
    end
  end

  // Divider registers.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      div_ff <= '0;
      fast_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      fast_ff <= link.fast;
      tick_ff <= nxt_tick;
    end
  end

  assign link.tick = tick_ff;

  // Independent gap counter for the period check.
  // The divider leaves zero in the tick cycle, so the gap restarts at one.
  logic [DIV_W-1:0] gap_ff;
  always_ff @(posedge CLOCK) begin
    if (RESET || link.fast != fast_ff || !link.enable) begin
      gap_ff <= '0;
    end else if (tick_ff) begin
      gap_ff <= DIV_W'(1);
    end else begin
      gap_ff <= gap_ff + 1'b1;
    end
  end

  a_osc_period_speed:
    assert property (@(posedge CLOCK) disable iff (RESET)
      (nxt_tick && link.fast == fast_ff) |->
        (gap_ff == (fast_ff ? DIV_W'(OSC_FULL_DIV - 1)
                            : DIV_W'(OSC_HALF_DIV - 1))))
    else $error("Oscillator period does not match gain range.");

endmodule
`default_nettype wire

// *** rtl/light_timing.sv ***
// Light sensor integration timing core with an Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Low gain ranges halve oscillator speed.
// - Internal mode ends after power-of-two cycles.
// - One command bit selects timing mode.
// - Host mode needs three syncs for the first result, then two per result.
// - Sync one starts array one; two switches.
// - Sync three publishes and restarts array one.
// - Host mode tallies oscillator cycles as timer.
// - Oscillator behaves alike in both modes.
// - Full scale is programmed count or tally.
// - Gain field changes apply at once, within a running conversion.
// - Width 00,01,10,11 give 65536,4096,256,16.
// - Mode bit zero internal, one host-timed.
// - Gain codes 00 to 11 are ranges 1-4.
// - Tally latched as 16-bit timer, low first.
module light_timing
  import light_timing_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Avalon-MM slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Converter side
  input wire logic [15:0] ADC_DATA,
  output logic DIODE_SELECT,
  output logic CONVERTING,
  output logic RESULT_PULSE,
  output logic [1:0] GAIN_RANGE
);

  // ********************************************************************
  // Width decode
  // ********************************************************************
  // Width field decode.
  function automatic logic [16:0] width_cycles(input logic [1:0] w);
    logic [16:0] c;
    c = CYCLES_W00;
    unique case (w)
      2'b00: c = CYCLES_W00;
      2'b01: c = CYCLES_W01;
      2'b10: c = CYCLES_W10;
      2'b11: c = CYCLES_W11;
    endcase
    return c;
  endfunction

  // ********************************************************************
  // State
  // ********************************************************************
  logic [7:0] command_ff, nxt_command;
  logic [7:0] control_ff, nxt_control;
  logic [15:0] data_ff, nxt_data;
  logic [15:0] timer_ff, nxt_timer;
  logic [16:0] full_ff, nxt_full;
  logic ovf_ff, nxt_ovf;
  phase_e phase_ff, nxt_phase;
  logic [16:0] count_ff, nxt_count;
  logic diode_ff, nxt_diode;
  logic pulse_ff, nxt_pulse;
  logic conv_ff, nxt_conv;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wait_ff, nxt_wait;

  logic enable, mode_ext, tick, publish, sync_req, wr_now;
  logic [3:0] index;
  logic [16:0] target, tally_now;
  osc_if osc ();

  assign index = AVS_ADDRESS[5:2];
  assign wr_now = AVS_WRITE && !wait_ff;
  assign enable = command_ff[CMD_ENABLE_BIT];
  assign mode_ext = command_ff[CMD_MODE_BIT];
  assign target = width_cycles(command_ff[CMD_WIDTH_LSB +: 2]);
  assign sync_req = wr_now && index == IDX_SYNC;
  assign tick = osc.tick;
  assign tally_now = count_ff + {16'h0000, tick};

  // Ranges 3 and 4 have the upper gain bit set.
  assign osc.enable = enable;
  assign osc.fast = control_ff[CTRL_GAIN_LSB + 1];

  conv_oscillator u_osc (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .link(osc)
  );

  // ********************************************************************
  // Integration sequencing
  // ********************************************************************
  // Next phase, tally and array selection for both timing modes.
  always_comb begin
    nxt_count = count_ff;
    nxt_phase = phase_ff;
    nxt_diode = diode_ff;
    publish = 1'b0;
    if (!enable) begin
      nxt_count = '0;
      nxt_phase = PH_IDLE;
      nxt_diode = 1'b0;
    end else if (!mode_ext) begin
      nxt_phase = PH_IDLE;
      if (tick) begin
        // Power-of-two end.
        // Comparing with >= keeps a mid-run width cut from overrunning.
        if (tally_now >= target) begin
          publish = 1'b1;
          nxt_count = '0;
          nxt_diode = 1'b0;
        end else begin
          nxt_count = tally_now;
          nxt_diode = tally_now >= (target >> 1);
        end
      end
    end else begin
      unique case (phase_ff)
        PH_IDLE: begin
          nxt_count = '0;
          if (sync_req) begin
            nxt_phase = PH_ARRAY1;
            nxt_diode = 1'b0;
          end
        end
        PH_ARRAY1: begin
          nxt_count = count_ff[16] ? count_ff : tally_now;
          if (sync_req) begin
            nxt_phase = PH_ARRAY2;
            nxt_diode = 1'b1;
          end
        end
        PH_ARRAY2: begin
          nxt_count = count_ff[16] ? count_ff : tally_now;
          if (sync_req) begin
            publish = 1'b1;
            nxt_phase = PH_ARRAY1;
            nxt_diode = 1'b0;
            nxt_count = '0;
          end
        end
        default: begin
          nxt_phase = PH_IDLE;
        end
      endcase
    end
  end

  // ********************************************************************
  // Registers and results
  // ********************************************************************
  // Register writes and result capture.
  always_comb begin
    nxt_command = command_ff;
    nxt_control = control_ff;
    nxt_data = data_ff;
    nxt_timer = timer_ff;
    nxt_full = full_ff;
    nxt_ovf = ovf_ff;
    nxt_pulse = publish;
    nxt_conv = enable && (!mode_ext || nxt_phase != PH_IDLE);
    if (wr_now && index == IDX_COMMAND) begin
      nxt_command = AVS_WRITEDATA[7:0];
    end
    if (wr_now && index == IDX_CONTROL) begin
      nxt_control = AVS_WRITEDATA[7:0];
    end
    if (wr_now && index == IDX_STATUS && AVS_WRITEDATA[STAT_OVF_BIT]) begin
      nxt_ovf = 1'b0;
    end
    // An overflow in the same cycle as the clear keeps the flag set.
    if (enable && mode_ext && count_ff[16]) begin
      nxt_ovf = 1'b1;
    end
    if (publish) begin
      nxt_data = ADC_DATA;
      nxt_timer = tally_now[15:0];
      nxt_full = mode_ext ? tally_now : target;
    end
  end

  // Avalon answer: one wait cycle, then data with waitrequest low.
  always_comb begin
    nxt_wait = !((AVS_READ || AVS_WRITE) && wait_ff);
    nxt_rdata = 32'h0000_0000;
    if (AVS_READ && wait_ff) begin
      unique case (index)
        IDX_COMMAND: nxt_rdata = {24'h000000, command_ff};
        IDX_CONTROL: nxt_rdata = {24'h000000, control_ff};
        IDX_DATA_LO: nxt_rdata = {24'h000000, data_ff[7:0]};
        IDX_DATA_HI: nxt_rdata = {24'h000000, data_ff[15:8]};
        IDX_TIMER_LO: nxt_rdata = {24'h000000, timer_ff[7:0]};
        IDX_TIMER_HI: nxt_rdata = {24'h000000, timer_ff[15:8]};
        IDX_STATUS: nxt_rdata = {28'h0000000, diode_ff, phase_ff, ovf_ff};
        IDX_FULL_LO: nxt_rdata = {24'h000000, full_ff[7:0]};
        IDX_FULL_HI: nxt_rdata = {23'h000000, full_ff[16:8]};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      command_ff <= COMMAND_RESET;
      control_ff <= CONTROL_RESET;
      data_ff <= '0;
      timer_ff <= '0;
      full_ff <= '0;
      ovf_ff <= 1'b0;
      phase_ff <= PH_IDLE;
      count_ff <= '0;
      diode_ff <= 1'b0;
      pulse_ff <= 1'b0;
      conv_ff <= 1'b0;
      rdata_ff <= '0;
      wait_ff <= 1'b1;
    end else begin
      command_ff <= nxt_command;
      control_ff <= nxt_control;
      data_ff <= nxt_data;
      timer_ff <= nxt_timer;
      full_ff <= nxt_full;
      ovf_ff <= nxt_ovf;
      phase_ff <= nxt_phase;
      count_ff <= nxt_count;
      diode_ff <= nxt_diode;
      pulse_ff <= nxt_pulse;
      conv_ff <= nxt_conv;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
    end
  end

  assign AVS_READDATA = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;
  assign DIODE_SELECT = diode_ff;
  assign CONVERTING = conv_ff;
  assign RESULT_PULSE = pulse_ff;
  assign GAIN_RANGE = control_ff[CTRL_GAIN_LSB +: 2];

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence s_host_armed;
    enable && mode_ext;
  endsequence

  sequence s_first_sync;
    s_host_armed ##0 (phase_ff == PH_IDLE && sync_req);
  endsequence

  sequence s_second_sync;
    s_host_armed ##0 (phase_ff == PH_ARRAY1 && sync_req);
  endsequence

  sequence s_third_sync;
    s_host_armed ##0 (phase_ff == PH_ARRAY2 && sync_req);
  endsequence

  a_first_sync_start:
    assert property (s_first_sync |=> phase_ff == PH_ARRAY1 && !DIODE_SELECT
      && count_ff == 17'h00000)
    else $error("First sync did not start array one.");

  a_second_sync_switch:
    assert property (s_second_sync |=> phase_ff == PH_ARRAY2 && DIODE_SELECT)
    else $error("Second sync did not switch to array two.");

  a_third_sync_result:
    assert property (s_third_sync |=> RESULT_PULSE && phase_ff == PH_ARRAY1
      && count_ff == 17'h00000 && !DIODE_SELECT)
    else $error("Third sync did not publish and restart.");

  a_result_only_third:
    assert property ((RESULT_PULSE && $past(mode_ext)) |->
      ($past(phase_ff) == PH_ARRAY2 && $past(sync_req)))
    else $error("Host-timed result without a third sync.");

  a_internal_end_count:
    assert property ((enable && !mode_ext && tick && tally_now == target)
      |=> RESULT_PULSE && full_ff == $past(target) && count_ff == 17'h00000)
    else $error("Internal integration did not end at the cycle count.");

  a_timer_value_latch:
    assert property (publish |=> timer_ff == $past(tally_now[15:0])
      && data_ff == $past(ADC_DATA))
    else $error("Timer or data not latched at integration end.");

  a_full_scale_host:
    assert property ((publish && mode_ext) |=> full_ff == $past(tally_now))
    else $error("Host-timed full scale differs from the tally.");

  a_internal_no_phase:
    assert property ((!mode_ext && !$past(mode_ext)) |-> phase_ff == PH_IDLE)
    else $error("Phase advanced in internal timing mode.");

  a_overflow_sticky:
    assert property ((enable && mode_ext && count_ff[16]) |=> ovf_ff)
    else $error("Tally overflow not flagged.");

  a_bus_answer_one:
    assert property (((AVS_READ || AVS_WRITE) && wait_ff) |=>
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("Bus answer not given after one wait cycle.");

endmodule
`default_nettype wire

// *** verif/adc_model.sv ***
// Behavioural converter that feeds result words to the timing core.
`timescale 1ns/1ns
`default_nettype none
// ****************************************************
// Converter model
// ****************************************************
module adc_model (
  // System
  input wire logic CLOCK,
  input wire logic RESET,
  // Core side
  input wire logic RESULT_PULSE,
  output logic [15:0] ADC_DATA,
  // Bench side
  output logic [15:0] PUBLISHED
);
  // A fresh word follows every result, so a stale sample is caught.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ADC_DATA <= 16'h1234;
      PUBLISHED <= 16'h0000;
    end else if (RESULT_PULSE) begin
      PUBLISHED <= ADC_DATA;
      ADC_DATA <= 16'($urandom);
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_light_timing.sv ***
// Self-checking bench for the light integration timing core.
`timescale 1ns/1ns
`default_nettype none
module tb_light_timing;
  import light_timing_pkg::*;
  // ****************************************************
  // Signals and bookkeeping
  // ****************************************************
  typedef struct {logic [31:0] v; int tol;} note_s;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [15:0] adc_data;
  logic [15:0] published;
  logic DIODE_SELECT;
  logic CONVERTING;
  logic RESULT_PULSE;
  logic [1:0] GAIN_RANGE;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_pulse = 0;
  note_s notes[$];

  // Free running 125 MHz clock.
  always #4 CLOCK = ~CLOCK;

  light_timing i_dut (
    .CLOCK(CLOCK), .RESET(RESET),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .ADC_DATA(adc_data), .DIODE_SELECT(DIODE_SELECT),
    .CONVERTING(CONVERTING), .RESULT_PULSE(RESULT_PULSE),
    .GAIN_RANGE(GAIN_RANGE)
  );

  adc_model i_adc (
    .CLOCK(CLOCK), .RESET(RESET), .RESULT_PULSE(RESULT_PULSE),
    .ADC_DATA(adc_data), .PUBLISHED(published)
  );

  // ****************************************************
  // Checking and closing
  // ****************************************************
  // A tolerance absorbs the free running divider phase at window edges.
  task cmp(input logic [31:0] got, input logic [31:0] exp, input int tol);
    checks_done++;
    if (!((^got !== 1'bx) && got + tol >= exp && got <= exp + tol)) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watches the outputs: read answers, result pulses and the time limit.
  always @(posedge CLOCK) begin
    note_s n;
    cyc <= cyc + 1;
    if (RESULT_PULSE === 1'b1) begin
      n_pulse <= n_pulse + 1;
    end
    if (avs_read === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      n = notes.pop_front();
      cmp(AVS_READDATA, n.v, n.tol);
    end
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****************************************************
  // Bus and wait tasks
  // ****************************************************
  // Request is held until waitrequest is sampled low, then released.
  // Only the bench timeout ends a wait that never gets an answer.
  task bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge CLOCK);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'($urandom), wd};
    do begin
      @(posedge CLOCK);
    end while (AVS_WAITREQUEST !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rd(input logic [3:0] idx, input logic [31:0] exp, input int tol);
    note_s n;
    n.v = exp;
    n.tol = tol;
    notes.push_back(n);
    bus(1'b0, idx, 8'h00);
  endtask

  task wait_pulse(output int at);
    int n;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (RESULT_PULSE !== 1'b1 && n < 12000);
    cmp(n < 12000, 1, 0);
    at = cyc;
  endtask

  task quiet(input int len);
    int b;
    b = n_pulse;
    repeat (len) @(posedge CLOCK);
    cmp(n_pulse, b, 0);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    int p1;
    int p2;
    int t0;
    int g;
    int d;
    logic [7:0] st;
    void'($urandom(31047));
    repeat (8) @(posedge CLOCK);
    RESET <= 1'b0;
    // Reset contents, unmapped and read-only places.
    rd(IDX_COMMAND, COMMAND_RESET, 0);
    rd(IDX_CONTROL, CONTROL_RESET, 0);
    rd(4'hf, 32'h0, 0);
    bus(1'b1, IDX_TIMER_LO, 8'hff);
    rd(IDX_TIMER_LO, 32'h0, 0);
    rd(IDX_SYNC, 32'h0, 0);
    // Internal timing with 16 ticks at every gain code.
    for (g = 0; g < 4; g++) begin
      d = (g < 2) ? OSC_HALF_DIV : OSC_FULL_DIV;
      bus(1'b1, IDX_COMMAND, 8'h00);
      bus(1'b1, IDX_CONTROL, 8'(g << CTRL_GAIN_LSB));
      bus(1'b1, IDX_COMMAND, 8'h83);
      wait_pulse(p1);
      wait_pulse(p2);
      cmp(p2 - p1, 16 * d, 0);
      cmp(GAIN_RANGE, g, 0);
      cmp(CONVERTING, 1, 0);
      rd(IDX_CONTROL, g << CTRL_GAIN_LSB, 0);
      rd(IDX_TIMER_LO, 32'h10, 0);
      rd(IDX_TIMER_HI, 32'h0, 0);
      rd(IDX_FULL_LO, 32'h10, 0);
      rd(IDX_FULL_HI, 32'h0, 0);
      rd(IDX_DATA_LO, published[7:0], 0);
      rd(IDX_DATA_HI, published[15:8], 0);
    end
    // Width 10 needs 256 ticks, so no result within the 3500 cycle span.
    bus(1'b1, IDX_COMMAND, 8'h00);
    bus(1'b1, IDX_COMMAND, 8'h82);
    quiet(3500);
    // Host timing gives no result without sync commands.
    bus(1'b1, IDX_COMMAND, 8'h00);
    bus(1'b1, IDX_COMMAND, 8'ha3);
    quiet(3500);
    cmp(CONVERTING, 0, 0);
    // Two host measurements back to back, at full and half speed.
    for (g = 3; g >= 0; g -= 3) begin
      d = (g < 2) ? OSC_HALF_DIV : OSC_FULL_DIV;
      bus(1'b1, IDX_COMMAND, 8'h00);
      bus(1'b1, IDX_CONTROL, 8'(g << CTRL_GAIN_LSB));
      bus(1'b1, IDX_COMMAND, 8'ha3);
      p1 = n_pulse;
      t0 = cyc;
      for (int k = 0; k < 5; k++) begin
        bus(1'b1, IDX_SYNC, 8'h01);
        st = (k % 2 == 1) ? 8'h0c : 8'h02;
        rd(IDX_STATUS, st, 0);
        cmp(DIODE_SELECT, st[3], 0);
        cmp(CONVERTING, 1, 0);
        cmp(n_pulse - p1, k / 2, 0);
        if (k % 2 == 0 && k > 0) begin
          rd(IDX_TIMER_LO, 20 * OSC_FULL_DIV / d, 1);
          rd(IDX_TIMER_HI, 32'h0, 0);
          rd(IDX_FULL_LO, 20 * OSC_FULL_DIV / d, 1);
        end
        while (cyc < t0 + (k + 1) * 10 * OSC_FULL_DIV) @(posedge CLOCK);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
